// *** include/otgsr_pkg.sv ***
// Constants for the OTG session and role support block.
// Assumes a single 125 MHz clock and a simple strobe register port.
package otgsr_pkg;
  // Register offsets, byte addresses on the 8-bit address port
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] FLAG_OFS = 8'h08;
  localparam logic [7:0] MASK_OFS = 8'h0c;
  localparam logic [7:0] TMR_OFS  = 8'h10;
  localparam logic [7:0] TCNT_OFS = 8'h14;
  localparam logic [7:0] CPUI_OFS = 8'h18;
  localparam logic [7:0] CPUE_OFS = 8'h1c;
  localparam logic [7:0] HWCF_OFS = 8'h20;

  // Control register fields
  localparam int VBUS_DRIVE_BIT = 0;
  localparam int VBUS_CHRG_BIT  = 1;
  localparam int VBUS_DCHG_BIT  = 2;
  localparam int LOC_PU_BIT     = 4;
  localparam int DP_PD_BIT      = 5;
  localparam int DM_PD_BIT      = 6;
  localparam int SRP_SEL_BIT    = 9;
  localparam int SRP_EN_BIT     = 10;

  // Status fields; pins occupy bits 0 to 6 in this order
  localparam int PLUG_BIT  = 0;
  localparam int BSEND_BIT = 2;
  localparam int ASESS_BIT = 3;
  localparam int BSESS_BIT = 4;
  localparam int DP_BIT    = 5;
  localparam int DM_BIT    = 6;
  localparam int JST_BIT   = 7;
  localparam int IDLE_BIT  = 8;
  localparam int SE0_BIT   = 9;

  // Event flag fields beyond the status-change flags 0 to 9, then the timer run, group and pin enable bits
  localparam int TOUT_BIT = 10;
  localparam int SRP_BIT  = 11;
  localparam int TMR_RUN_BIT = 31;
  localparam int GRP_BIT  = 9;
  localparam int PIN_EN_BIT = 0;
  localparam logic [11:0] WAKE_SET = 12'h811;

  // Reset values
  localparam logic [10:0] CTRL_RST = 11'h000;
  localparam logic [11:0] MASK_RST = 12'h000;
  localparam logic [15:0] TMR_RST  = 16'h0000;

  // Timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int TICK_NS       = 10000;
  localparam int TICK_CYC      = TICK_NS / CLK_PERIOD_NS;
  localparam int LONG_SE0_US   = 2000;
  localparam int BUS_IDLE_US   = 3000;
  localparam int LONG_SE0_CYC  = (LONG_SE0_US * 1000) / CLK_PERIOD_NS;
  localparam int BUS_IDLE_CYC  = (BUS_IDLE_US * 1000) / CLK_PERIOD_NS;
endpackage

// *** rtl/otgsr_top.sv ***
// OTG session and role support: control outputs, filtered status,
// event flags, interval timer and the shared interrupt pin latch.
// Assumes line-state and VBUS comparator pins are asynchronous.
//
// The implementer's own choices: the address map and strobed register access.
module otgsr_top #(
  parameter int unsigned LONG_SE0_CYC = otgsr_pkg::LONG_SE0_CYC,
  parameter int unsigned BUS_IDLE_CYC = otgsr_pkg::BUS_IDLE_CYC
) (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        ARST_N,
  // Register port
  input  wire logic [7:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [31:0] RDATA,
  // Bus and plug comparators
  input  wire logic        PLUG_TYPE_PIN,
  input  wire logic        A_VBUS_VLD,
  input  wire logic        B_SESS_END,
  input  wire logic        A_SESS_VLD,
  input  wire logic        B_SESS_VLD,
  input  wire logic        DP_IN,
  input  wire logic        DM_IN,
  // Analog controls
  output logic             VBUS_DRIVE,
  output logic             VBUS_CHARGE,
  output logic             VBUS_DISCHARGE,
  output logic             DP_PULLUP,
  output logic             DP_PULLDOWN,
  output logic             DM_PULLDOWN,
  output logic             A_DEVICE,
  // Interrupt and power
  input  wire logic        HOST_IRQ,
  input  wire logic        SAVE_MODE,
  output logic             PRIMARY_IRQ,
  output logic             WAKE_REQ
);

  typedef struct packed {
    logic [6:0]  s1;
    logic [6:0]  s2;
    logic [6:0]  s3;
    logic [6:0]  filt;
    logic [9:0]  prev;
    logic [10:0] ctrl;
    logic [11:0] flags;
    logic [11:0] mask;
    logic [15:0] ivl;
    logic        run;
    logic [15:0] tcnt;
    logic [10:0] div;
    logic [19:0] se0_cnt;
    logic [19:0] idle_cnt;
    logic        grp;
    logic        grp_en;
    logic        pin_en;
    logic        irq;
    logic        wake;
    logic [31:0] rdata;
  } otgsr_state_t;

  otgsr_state_t st_reg;
  otgsr_state_t st_next;

  // Sticky update where a new event beats a same-cycle clear
  function automatic logic [11:0] otgsr_w1c(logic [11:0] cur, logic [11:0] clr,
                                            logic [11:0] set);
    return set | (cur & ~clr);
  endfunction

  logic [9:0]  status;
  logic [6:0]  agree;
  logic        se0_long;
  logic        idle_long;
  logic        tick;
  logic        dl_edge;
  logic        vb_edge;
  logic        srp_ev;
  logic        tout_ev;
  logic [11:0] grp_upd;
  logic [11:0] ev;
  logic        wr_flag;
  logic        wr_cpui;

  assign se0_long  = st_reg.se0_cnt >= 20'(LONG_SE0_CYC);
  assign idle_long = st_reg.idle_cnt >= 20'(BUS_IDLE_CYC);
  assign status = {se0_long, idle_long,
                   st_reg.filt[otgsr_pkg::DP_BIT] & ~st_reg.filt[otgsr_pkg::DM_BIT],
                   st_reg.filt};
  assign tick = st_reg.div == 11'(otgsr_pkg::TICK_CYC - 1);
  assign wr_flag = WR && ADDR == otgsr_pkg::FLAG_OFS;
  assign wr_cpui = WR && ADDR == otgsr_pkg::CPUI_OFS;

  always_comb begin
    st_next = st_reg;
    // Only the second stage reads the first
    st_next.s1 = {DM_IN, DP_IN, B_SESS_VLD, A_SESS_VLD, B_SESS_END, A_VBUS_VLD, PLUG_TYPE_PIN};
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    agree = ~(st_reg.s2 ^ st_reg.s3);
    st_next.filt = (st_reg.s3 & agree) | (st_reg.filt & ~agree);

    // Line-state timers; the idle bit lets software confirm the 3000 us settle
    if (st_next.filt[6:5] != 2'b00) begin
      st_next.se0_cnt = 20'h00000;
    end else if (!se0_long) begin
      st_next.se0_cnt = st_reg.se0_cnt + 20'h00001;
    end
    if (st_next.filt[6:5] != st_reg.filt[6:5]) begin
      st_next.idle_cnt = 20'h00000;
    end else if (!idle_long) begin
      st_next.idle_cnt = st_reg.idle_cnt + 20'h00001;
    end

    // SRP detection on the A side only
    dl_edge = (~st_reg.filt[otgsr_pkg::DP_BIT] & st_next.filt[otgsr_pkg::DP_BIT]) |
              (~st_reg.filt[otgsr_pkg::DM_BIT] & st_next.filt[otgsr_pkg::DM_BIT]);
    vb_edge = ~st_reg.filt[otgsr_pkg::ASESS_BIT] & st_next.filt[otgsr_pkg::ASESS_BIT] &
              ~st_reg.ctrl[otgsr_pkg::VBUS_DRIVE_BIT];
    srp_ev = st_reg.ctrl[otgsr_pkg::SRP_EN_BIT] & ~st_reg.filt[otgsr_pkg::PLUG_BIT] &
             (st_reg.ctrl[otgsr_pkg::SRP_SEL_BIT] ? dl_edge : vb_edge);

    // Interval timer in 10 us units
    tout_ev = 1'b0;
    if (st_reg.run) begin
      st_next.div = tick ? 11'h000 : st_reg.div + 11'h001;
      if (tick) begin
        st_next.tcnt = st_reg.tcnt + 16'h0001;
        if (st_reg.tcnt + 16'h0001 >= st_reg.ivl) begin
          tout_ev = 1'b1;
          st_next.run = 1'b0;
        end
      end
    end
    if (WR && ADDR == otgsr_pkg::TMR_OFS) begin
      st_next.ivl  = WDATA[15:0];
      st_next.run  = WDATA[otgsr_pkg::TMR_RUN_BIT];
      st_next.tcnt = 16'h0000;
      st_next.div  = 11'h000;
    end

    // Event flags
    st_next.prev = status;
    ev = {srp_ev, tout_ev, status ^ st_reg.prev};
    st_next.flags = otgsr_w1c(st_reg.flags, wr_flag ? WDATA[11:0] : 12'h000, ev);
    grp_upd = otgsr_w1c({11'h000, st_reg.grp},
                        {11'h000, wr_cpui & WDATA[otgsr_pkg::GRP_BIT]},
                        {11'h000, |(st_reg.flags & st_reg.mask)});
    st_next.grp = grp_upd[0];

    // Pin latch holds its level while the latch enable is clear
    if (st_reg.pin_en) begin
      st_next.irq = (st_reg.grp & st_reg.grp_en) | HOST_IRQ;
    end
    st_next.wake = SAVE_MODE & |(st_next.flags & st_reg.mask & otgsr_pkg::WAKE_SET);

    // Register writes
    if (WR) begin
      unique case (ADDR)
        otgsr_pkg::CTRL_OFS: st_next.ctrl = WDATA[10:0];
        otgsr_pkg::MASK_OFS: st_next.mask = WDATA[11:0];
        otgsr_pkg::CPUE_OFS: st_next.grp_en = WDATA[otgsr_pkg::GRP_BIT];
        otgsr_pkg::HWCF_OFS: st_next.pin_en = WDATA[otgsr_pkg::PIN_EN_BIT];
        default: ;
      endcase
    end

    // Read data one cycle after the strobe, zero otherwise
    st_next.rdata = 32'h00000000;
    if (RD) begin
      unique case (ADDR)
        otgsr_pkg::CTRL_OFS: st_next.rdata = {21'h000000, st_reg.ctrl};
        otgsr_pkg::STAT_OFS: st_next.rdata = {22'h000000, status};
        otgsr_pkg::FLAG_OFS: st_next.rdata = {20'h00000, st_reg.flags};
        otgsr_pkg::MASK_OFS: st_next.rdata = {20'h00000, st_reg.mask};
        otgsr_pkg::TMR_OFS:  st_next.rdata = {st_reg.run, 15'h0000, st_reg.ivl};
        otgsr_pkg::TCNT_OFS: st_next.rdata = {16'h0000, st_reg.tcnt};
        otgsr_pkg::CPUI_OFS: st_next.rdata = {22'h000000, st_reg.grp, 9'h000};
        otgsr_pkg::CPUE_OFS: st_next.rdata = {22'h000000, st_reg.grp_en, 9'h000};
        otgsr_pkg::HWCF_OFS: st_next.rdata = {31'h00000000, st_reg.pin_en};
        default: st_next.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st_reg      <= '0;
      st_reg.ctrl <= otgsr_pkg::CTRL_RST;
      st_reg.mask <= otgsr_pkg::MASK_RST;
      st_reg.ivl  <= otgsr_pkg::TMR_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // Controls go straight out so software owns every pulse width
  assign VBUS_DRIVE     = st_reg.ctrl[otgsr_pkg::VBUS_DRIVE_BIT];
  assign VBUS_CHARGE    = st_reg.ctrl[otgsr_pkg::VBUS_CHRG_BIT];
  assign VBUS_DISCHARGE = st_reg.ctrl[otgsr_pkg::VBUS_DCHG_BIT];
  assign DP_PULLUP      = st_reg.ctrl[otgsr_pkg::LOC_PU_BIT];
  assign DP_PULLDOWN    = st_reg.ctrl[otgsr_pkg::DP_PD_BIT];
  assign DM_PULLDOWN    = st_reg.ctrl[otgsr_pkg::DM_PD_BIT];
  assign A_DEVICE       = ~st_reg.filt[otgsr_pkg::PLUG_BIT];
  assign PRIMARY_IRQ    = st_reg.irq;
  assign WAKE_REQ       = st_reg.wake;
  assign RDATA          = st_reg.rdata;

  property p_role;
    @(posedge CLK) disable iff (!ARST_N)
      st_reg.s2[otgsr_pkg::PLUG_BIT] == st_reg.s3[otgsr_pkg::PLUG_BIT]
      |=> A_DEVICE == !$past(st_reg.s3[otgsr_pkg::PLUG_BIT]);
  endproperty
  a_role: assert property (p_role) else $error("role disagrees with plug");

  property p_pullup;
    @(posedge CLK) disable iff (!ARST_N)
      WR && ADDR == otgsr_pkg::CTRL_OFS |=> DP_PULLUP == $past(WDATA[otgsr_pkg::LOC_PU_BIT]);
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up not from control");

  property p_charge;
    @(posedge CLK) disable iff (!ARST_N)
      !WR |=> $stable(VBUS_CHARGE);
  endproperty
  a_charge: assert property (p_charge) else $error("charge moved without write");

  property p_srp_off;
    @(posedge CLK) disable iff (!ARST_N)
      !st_reg.ctrl[otgsr_pkg::SRP_EN_BIT] && !st_reg.flags[otgsr_pkg::SRP_BIT]
      |=> !st_reg.flags[otgsr_pkg::SRP_BIT];
  endproperty
  a_srp_off: assert property (p_srp_off) else $error("SRP seen while disabled");

  property p_tout;
    @(posedge CLK) disable iff (!ARST_N)
      st_reg.run && tick && st_reg.tcnt + 16'h0001 == st_reg.ivl && !WR
      |=> st_reg.flags[otgsr_pkg::TOUT_BIT] && !st_reg.run;
  endproperty
  a_tout: assert property (p_tout) else $error("timer expiry not flagged");

  property p_flag;
    @(posedge CLK) disable iff (!ARST_N)
      status[otgsr_pkg::BSESS_BIT] != st_reg.prev[otgsr_pkg::BSESS_BIT]
      |=> st_reg.flags[otgsr_pkg::BSESS_BIT];
  endproperty
  a_flag: assert property (p_flag) else $error("status change not latched");

  property p_hold;
    @(posedge CLK) disable iff (!ARST_N)
      !st_reg.pin_en |=> PRIMARY_IRQ == $past(PRIMARY_IRQ);
  endproperty
  a_hold: assert property (p_hold) else $error("pin moved while latched");

  property p_status_rd;
    @(posedge CLK) disable iff (!ARST_N)
      RD && ADDR == otgsr_pkg::STAT_OFS |=> RDATA[9:0] == $past(status) && RDATA[31:10] == 22'h000000;
  endproperty
  a_status_rd: assert property (p_status_rd) else $error("status read wrong");

  property p_wake;
    @(posedge CLK) disable iff (!ARST_N)
      WAKE_REQ |-> $past(SAVE_MODE) && |(st_reg.flags & otgsr_pkg::WAKE_SET);
  endproperty
  a_wake: assert property (p_wake) else $error("wake without enabled event");

  property p_dp_srp;
    @(posedge CLK) disable iff (!ARST_N)
      st_reg.ctrl[otgsr_pkg::SRP_EN_BIT] && st_reg.ctrl[otgsr_pkg::SRP_SEL_BIT] &&
      !st_reg.filt[otgsr_pkg::PLUG_BIT] && !st_reg.filt[otgsr_pkg::DP_BIT] &&
      st_reg.s2[otgsr_pkg::DP_BIT] && st_reg.s3[otgsr_pkg::DP_BIT] |=> st_reg.flags[otgsr_pkg::SRP_BIT];
  endproperty
  a_dp_srp: assert property (p_dp_srp) else $error("DP pulse not taken as session request");

  property p_dm_srp;
    @(posedge CLK) disable iff (!ARST_N)
      st_reg.ctrl[otgsr_pkg::SRP_EN_BIT] && st_reg.ctrl[otgsr_pkg::SRP_SEL_BIT] &&
      !st_reg.filt[otgsr_pkg::PLUG_BIT] && !st_reg.filt[otgsr_pkg::DM_BIT] &&
      st_reg.s2[otgsr_pkg::DM_BIT] && st_reg.s3[otgsr_pkg::DM_BIT] |=> st_reg.flags[otgsr_pkg::SRP_BIT];
  endproperty
  a_dm_srp: assert property (p_dm_srp) else $error("DM pulse not taken as session request");

  property p_vb_srp;
    @(posedge CLK) disable iff (!ARST_N)
      st_reg.ctrl[otgsr_pkg::SRP_EN_BIT] && !st_reg.ctrl[otgsr_pkg::SRP_SEL_BIT] &&
      !st_reg.filt[otgsr_pkg::PLUG_BIT] && !st_reg.ctrl[otgsr_pkg::VBUS_DRIVE_BIT] &&
      !st_reg.filt[otgsr_pkg::ASESS_BIT] && st_reg.s2[otgsr_pkg::ASESS_BIT] &&
      st_reg.s3[otgsr_pkg::ASESS_BIT] |=> st_reg.flags[otgsr_pkg::SRP_BIT];
  endproperty
  a_vb_srp: assert property (p_vb_srp) else $error("VBUS pulse not taken as session request");

  property p_b_side;
    @(posedge CLK) disable iff (!ARST_N)
      st_reg.filt[otgsr_pkg::PLUG_BIT] && !st_reg.flags[otgsr_pkg::SRP_BIT]
      |=> !st_reg.flags[otgsr_pkg::SRP_BIT];
  endproperty
  a_b_side: assert property (p_b_side) else $error("session request seen on B side");

  property p_tmr_load;
    @(posedge CLK) disable iff (!ARST_N)
      WR && ADDR == otgsr_pkg::TMR_OFS |=> st_reg.tcnt == 16'h0000 && st_reg.ivl == $past(WDATA[15:0]) &&
      st_reg.run == $past(WDATA[otgsr_pkg::TMR_RUN_BIT]);
  endproperty
  a_tmr_load: assert property (p_tmr_load) else $error("timer not restarted by write");

  property p_irq_pin;
    @(posedge CLK) disable iff (!ARST_N)
      st_reg.pin_en |=> PRIMARY_IRQ == $past((st_reg.grp && st_reg.grp_en) || HOST_IRQ);
  endproperty
  a_irq_pin: assert property (p_irq_pin) else $error("pin does not follow group and host");

  property p_grp_set;
    @(posedge CLK) disable iff (!ARST_N)
      |(st_reg.flags & st_reg.mask) |=> st_reg.grp;
  endproperty
  a_grp_set: assert property (p_grp_set) else $error("enabled flag missed group bit");

  property p_wake_off;
    @(posedge CLK) disable iff (!ARST_N)
      !SAVE_MODE |=> !WAKE_REQ;
  endproperty
  a_wake_off: assert property (p_wake_off) else $error("wake outside power save");

  property p_ctrl_out;
    @(posedge CLK) disable iff (!ARST_N)
      !(WR && ADDR == otgsr_pkg::CTRL_OFS)
      |=> $stable({VBUS_DRIVE, VBUS_CHARGE, VBUS_DISCHARGE, DP_PULLUP, DP_PULLDOWN, DM_PULLDOWN});
  endproperty
  a_ctrl_out: assert property (p_ctrl_out) else $error("control output moved without write");

  property p_sticky;
    @(posedge CLK) disable iff (!ARST_N)
      !wr_flag |=> (st_reg.flags & $past(st_reg.flags)) == $past(st_reg.flags);
  endproperty
  a_sticky: assert property (p_sticky) else $error("event flag lost without clear");

  property p_rd_idle;
    @(posedge CLK) disable iff (!ARST_N)
      !RD |=> RDATA == 32'h00000000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");

  property p_se0_stat;
    @(posedge CLK) disable iff (!ARST_N)
      status[otgsr_pkg::SE0_BIT] |-> !st_reg.filt[otgsr_pkg::DP_BIT] && !st_reg.filt[otgsr_pkg::DM_BIT];
  endproperty
  a_se0_stat: assert property (p_se0_stat) else $error("long SE0 shown with a line high");

endmodule // otgsr_top

// *** sim/otgsr_far.sv ***
// Far-side model: remote OTG device and cable for the session block.
// Assumes the bench commands the remote pull-ups and VBUS pulsing.
module otgsr_far (
  // Local side
  input  wire logic clk,
  input  wire logic vbus_drive,
  input  wire logic vbus_charge,
  input  wire logic dp_pullup,
  // Bench commands
  input  wire logic rem_dp_pu,
  input  wire logic rem_dm_pu,
  input  wire logic rem_vbus,
  // Comparator and line levels
  output logic      a_vbus_vld,
  output logic      sess_vld,
  output logic      sess_end,
  output logic      dp,
  output logic      dm
);
  timeunit 1ns;
  timeprecision 1ps;
  logic vbus;
  assign vbus = vbus_drive | vbus_charge | rem_vbus;
  // Released lines fall to the pull-down level, not the last value
  always @(posedge clk) begin
    a_vbus_vld <= #1 vbus_drive;
    sess_vld   <= #1 vbus;
    sess_end   <= #1 ~vbus;
    dp         <= #1 dp_pullup | rem_dp_pu;
    dm         <= #1 rem_dm_pu;
  end
endmodule // otgsr_far

// *** sim/otgsr_top_tb.sv ***
// Testbench for the OTG session and role support block.
// Assumes the far-side model drives all comparator and line inputs but the plug pin, which the bench drives.
module otgsr_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] CTRL_A = otgsr_pkg::CTRL_OFS;
  localparam logic [7:0] STAT_A = otgsr_pkg::STAT_OFS;
  localparam logic [7:0] FLAG_A = otgsr_pkg::FLAG_OFS;
  localparam logic [7:0] MASK_A = otgsr_pkg::MASK_OFS;
  logic        clk, arst_n, wr_s, rd_s, plug, host_irq, save_mode, rdp, rdm, rvb;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, d;
  logic        av, sv, se, dp, dm, vd, vc, vx, pu, dpd, dmd, adev, irq, wake;
  int          errors, cmp_count, cyc;

  otgsr_top #(.LONG_SE0_CYC(20), .BUS_IDLE_CYC(30)) dut (
    .CLK(clk), .ARST_N(arst_n), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s), .RDATA(rdata),
    .PLUG_TYPE_PIN(plug), .A_VBUS_VLD(av), .B_SESS_END(se), .A_SESS_VLD(sv), .B_SESS_VLD(sv),
    .DP_IN(dp), .DM_IN(dm), .VBUS_DRIVE(vd), .VBUS_CHARGE(vc), .VBUS_DISCHARGE(vx),
    .DP_PULLUP(pu), .DP_PULLDOWN(dpd), .DM_PULLDOWN(dmd), .A_DEVICE(adev),
    .HOST_IRQ(host_irq), .SAVE_MODE(save_mode), .PRIMARY_IRQ(irq), .WAKE_REQ(wake));

  otgsr_far far (.clk(clk), .vbus_drive(vd), .vbus_charge(vc), .dp_pullup(pu), .rem_dp_pu(rdp),
    .rem_dm_pu(rdm), .rem_vbus(rvb), .a_vbus_vld(av), .sess_vld(sv), .sess_end(se), .dp(dp), .dm(dm));

  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end

  task automatic cyc_wait(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      $display("Error t=%0t got %h exp %h", $time, g, e);
      errors++;
    end
  endtask

  task automatic final_report;
    $display("errors=%0d cmp_count=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Hang guard, well above the few thousand cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      final_report;
    end
  end

  initial begin
    int bits[6] = '{0, 1, 2, 4, 5, 6};
    arst_n = 0; addr = 0; wdata = 0; wr_s = 0; rd_s = 0; plug = 0;
    host_irq = 0; save_mode = 0; rdp = 0; rdm = 0; rvb = 0;
    cyc_wait(10);
    chk({vd, vc, vx, pu, dpd, dmd, irq, wake, adev}, 9'h001);
    arst_n <= 1'b1;
    rd(CTRL_A, d); chk(d, 0);
    rd(MASK_A, d); chk(d, 0);
    rd(8'h24, d); chk(d, 0);
    foreach (bits[i]) begin
      wr(CTRL_A, 32'h1 << bits[i]);
      rd(CTRL_A, d); chk(d, 32'h1 << bits[i]);
      chk({dmd, dpd, pu, 1'b0, vx, vc, vd}, 7'h1 << bits[i]);
      cyc_wait(6);
      rd(STAT_A, d); chk(d[7:0], {bits[i] == 4, 1'b0, bits[i] == 4, {2{bits[i] < 2}}, bits[i] > 1, bits[i] == 0, 1'b0});
    end
    wr(CTRL_A, 0);
    plug <= 1'b1;
    cyc_wait(8);
    chk(adev, 0);
    rd(STAT_A, d); chk(d[0], 1);
    plug <= 1'b0;
    cyc_wait(8);
    chk(adev, 1);
    // Every detect mode against every pulse kind
    for (int m = 0; m < 4; m++) begin
      for (int s = 0; s < 3; s++) begin
        wr(CTRL_A, m << 9);
        cyc_wait(8);
        wr(FLAG_A, 32'hfff);
        rdp <= s == 0; rdm <= s == 1; rvb <= s == 2;
        cyc_wait(10);
        rdp <= 0; rdm <= 0; rvb <= 0;
        cyc_wait(10);
        rd(FLAG_A, d); chk(d[11], m > 1 && (m[0] ? s < 2 : s == 2));
      end
    end
    wr(CTRL_A, 0);
    wr(MASK_A, 32'h400);
    wr(otgsr_pkg::CPUE_OFS, 32'h200);
    wr(otgsr_pkg::HWCF_OFS, 1);
    cyc_wait(10);
    wr(FLAG_A, 32'hfff);
    wr(otgsr_pkg::CPUI_OFS, 32'h200);
    wr(otgsr_pkg::TMR_OFS, 32'h8000_0002);
    cyc_wait(2400);
    rd(FLAG_A, d); chk(d[10], 0);
    chk(irq, 0);
    cyc_wait(150);
    rd(FLAG_A, d); chk(d[10], 1);
    cyc_wait(4);
    chk(irq, 1);
    rd(otgsr_pkg::CPUI_OFS, d); chk(d[9], 1);
    rd(otgsr_pkg::TCNT_OFS, d); chk(d, 32'h0000_0002);
    rd(otgsr_pkg::TMR_OFS, d); chk(d, 32'h0000_0002);
    wr(otgsr_pkg::HWCF_OFS, 0);
    wr(FLAG_A, 32'hfff);
    wr(otgsr_pkg::CPUI_OFS, 32'h200);
    cyc_wait(4);
    chk(irq, 1);
    wr(otgsr_pkg::HWCF_OFS, 1);
    cyc_wait(4);
    chk(irq, 0);
    host_irq <= 1'b1;
    cyc_wait(3);
    chk(irq, 1);
    host_irq <= 1'b0;
    cyc_wait(3);
    chk(irq, 0);
    wr(MASK_A, 0);
    wr(otgsr_pkg::TMR_OFS, 32'h8000_0000);
    cyc_wait(1400);
    rd(FLAG_A, d); chk(d[10], 1);
    chk(irq, 0);
    save_mode <= 1'b1;
    wr(FLAG_A, 32'hfff);
    wr(MASK_A, 1);
    cyc_wait(2);
    chk(wake, 0);
    plug <= 1'b1;
    cyc_wait(10);
    chk(wake, 1);
    wr(MASK_A, 0);
    wr(FLAG_A, 32'hfff);
    plug <= 1'b0;
    cyc_wait(10);
    chk(wake, 0);
    wr(CTRL_A, 32'h10);
    cyc_wait(20);
    rd(STAT_A, d); chk(d[9:8], 0);
    cyc_wait(20);
    rd(STAT_A, d); chk(d[9:8], 2'b01);
    wr(CTRL_A, 0);
    cyc_wait(4);
    rd(STAT_A, d); chk(d[9], 0);
    cyc_wait(40);
    rd(STAT_A, d); chk(d[9:8], 2'b11);
    final_report;
  end
endmodule // otgsr_top_tb
